// *** src/enable_sync_power_good_ctrl.sv ***
// enable, sync lock and power-good control of a step-down regulator
`timescale 1ns/1ns
`include "pwr_seq_regs.svh"

// Overview of operation
// - below wake level: shutdown, supply off
// - between levels: supply on, no switching
// - above turn-on and input ok: switch
// - blank enable changes after sync edge
// - no blanking while in shutdown
// - sync clock within range, switching follows
// - after 2048 sync cycles adopt frequency
// - valid sync disables spread spectrum
// - transition cycle of intermediate length
// - phase slides to align sync edges
// - bad frequency resistor stops switching, supply stays on
// - window thresholds with hysteresis on return
// - deglitch out-of-window faults
// - enable low forces flag low
// - release delay before flag goes high
// - temperature, enable, supply faults
// - flag low during soft start
// - select main input when aux low
// - inhibit switching under supply lockout
module enable_sync_power_good_ctrl #(
    parameter int unsigned RELEASE_CYC = `RELEASE_CYC,
    parameter int unsigned RAMP_CYC = `RAMP_CYC,
    parameter int unsigned LOCK_CNT = `SYNC_LOCK_CNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_cmp,
    input wire logic turn_on_cmp,
    input wire logic sync_edge_in,
    input wire logic vin_ok_cmp,
    input wire logic rt_ok_cmp,
    input wire logic fb_under_cmp,
    input wire logic fb_over_cmp,
    input wire logic fb_in_band_cmp,
    input wire logic overtemp_trip,
    input wire logic overtemp_clear,
    input wire logic vcc_uvlo_cmp,
    input wire logic vcc_ok_cmp,
    input wire logic aux_supply_ok_cmp,
    input wire logic out_full_cmp,
    output logic internal_supply_en,
    output logic phase_node_en,
    output logic use_main_input,
    output logic ssc_en,
    output logic sync_locked,
    output logic phase_adjusting,
    output logic power_ok_flag_o,
    output logic power_ok_flag_oe
);

    localparam int unsigned NIN = 14;
    // two-flop synchronisers for all comparator inputs
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] meta_q;
    logic [NIN-1:0] sync_q;
    logic [NIN-1:0] prev_q;
    assign raw_in = {wake_cmp, turn_on_cmp, sync_edge_in, vin_ok_cmp,
        rt_ok_cmp, fb_under_cmp, fb_over_cmp, fb_in_band_cmp,
        overtemp_trip, overtemp_clear, vcc_uvlo_cmp, vcc_ok_cmp,
        aux_supply_ok_cmp, out_full_cmp};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= raw_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
    wire s_wake = sync_q[13];
    wire s_on = sync_q[12];
    wire s_sync = sync_q[11];
    wire s_vin = sync_q[10];
    wire s_rt = sync_q[9];
    wire s_under = sync_q[8];
    wire s_over = sync_q[7];
    wire s_band = sync_q[6];
    wire s_ot = sync_q[5];
    wire s_ot_clr = sync_q[4];
    wire s_uvlo = sync_q[3];
    wire s_vcc_ok = sync_q[2];
    wire s_aux = sync_q[1];
    wire s_full = sync_q[0];
    wire sync_rise = s_sync & ~prev_q[11];
    wire sync_fall = ~s_sync & prev_q[11];
    wire sync_edge = sync_rise | sync_fall;

    // apb registers
    logic [31:0] ctrl_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    // the answer cycle is not a new access: pready_q masks it
    wire acc = psel & penable & ~pready_q;
    wire hit_ctrl = paddr == `CTRL_OFS;
    wire hit_stat = paddr == `STAT_OFS;
    wire hit_sync = paddr == `SYNC_OFS;
    wire hit_any = hit_ctrl | hit_stat | hit_sync;
    // a write lands on the edge at which the master sees pready
    wire wr_ctrl = psel & penable & pready_q & pwrite & hit_ctrl;

    // enable blanking after sync edges, not in shutdown
    pwr_seq_pkg::seq_state_t state_q;
    pwr_seq_pkg::seq_state_t state_d;
    logic [15:0] blank_q;
    logic en_q;
    wire blanking = blank_q != 16'h0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            blank_q <= 16'h0000;
            en_q <= 1'b0;
        end
        else
        begin
            if (sync_edge && state_q != pwr_seq_pkg::ST_OFF)
                blank_q <= 16'(`BLANK_CYC);
            else if (blanking)
                blank_q <= blank_q - 16'h0001;
            // a fall is believed only once the window has run out;
            // a rise with no window running is taken at once
            if (state_q == pwr_seq_pkg::ST_OFF)
                en_q <= s_on;
            else if (!blanking && (s_on || !sync_edge))
                en_q <= s_on;
        end
    end

    // power-up sequencing
    logic [31:0] ramp_q;
    wire run_ok = en_q & s_vin & s_rt & ~s_uvlo & s_wake;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            pwr_seq_pkg::ST_OFF:
                if (s_wake)
                    state_d = pwr_seq_pkg::ST_WAKE;
            pwr_seq_pkg::ST_WAKE:
                if (!s_wake)
                    state_d = pwr_seq_pkg::ST_OFF;
                else if (run_ok)
                    state_d = pwr_seq_pkg::ST_SOFT;
            pwr_seq_pkg::ST_SOFT:
                if (!run_ok)
                    state_d = s_wake ? pwr_seq_pkg::ST_WAKE
                        : pwr_seq_pkg::ST_OFF;
                // soft start ends at full output or at the ramp limit
                else if (s_full || ramp_q >= RAMP_CYC)
                    state_d = pwr_seq_pkg::ST_RUN;
            pwr_seq_pkg::ST_RUN:
                if (!run_ok)
                    state_d = s_wake ? pwr_seq_pkg::ST_WAKE
                        : pwr_seq_pkg::ST_OFF;
            default:
                state_d = pwr_seq_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= pwr_seq_pkg::ST_OFF;
            ramp_q <= 32'h0000_0000;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == pwr_seq_pkg::ST_SOFT)
                ramp_q <= ramp_q + 32'h0000_0001;
            else
                ramp_q <= 32'h0000_0000;
        end
    end

    // sync period measurement and lock
    logic [15:0] per_cnt_q;
    logic [15:0] sync_per_q;
    logic [11:0] lock_cnt_q;
    logic locked_q;
    logic [5:0] phase_q;
    wire per_ok = per_cnt_q >= 16'(`SYNC_MIN_PER_CYC)
        && per_cnt_q <= 16'(`SYNC_MAX_PER_CYC);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            per_cnt_q <= 16'h0000;
            sync_per_q <= 16'h0000;
            lock_cnt_q <= 12'h000;
            locked_q <= 1'b0;
            phase_q <= 6'h00;
        end
        else if (state_q != pwr_seq_pkg::ST_RUN)
        begin
            per_cnt_q <= 16'h0000;
            lock_cnt_q <= 12'h000;
            locked_q <= 1'b0;
            phase_q <= 6'h00;
        end
        else
        begin
            if (sync_rise)
                per_cnt_q <= 16'h0001;
            else if (per_cnt_q != 16'hFFFF)
                per_cnt_q <= per_cnt_q + 16'h0001;
            if (sync_rise && !per_ok)
            begin
                lock_cnt_q <= 12'h000;
                locked_q <= 1'b0;
            end
            else if (sync_rise && !locked_q)
            begin
                sync_per_q <= per_cnt_q;
                if (32'(lock_cnt_q) + 1 >= LOCK_CNT)
                begin
                    locked_q <= 1'b1;
                    phase_q <= 6'(`PHASE_STEPS);
                end
                else
                    lock_cnt_q <= lock_cnt_q + 12'h001;
            end
            else if (sync_rise && phase_q != 6'h00)
                phase_q <= phase_q - 6'h01;
            // a gap longer than the slowest valid period drops lock
            if (!locked_q && per_cnt_q > 16'(`SYNC_MAX_PER_CYC))
                lock_cnt_q <= 12'h000;
            if (locked_q && per_cnt_q > 16'(`SYNC_MAX_PER_CYC))
                locked_q <= 1'b0;
        end
    end

    // power-good fault detection with deglitch and release delay
    logic [15:0] glitch_q;
    logic win_fault_q;
    logic ot_fault_q;
    logic [31:0] rel_q;
    logic pg_q;
    wire out_win = s_under | s_over;
    wire in_reg = s_band;
    wire any_fault = win_fault_q | ot_fault_q | ~en_q | s_uvlo
        | state_q != pwr_seq_pkg::ST_RUN;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            glitch_q <= 16'h0000;
            win_fault_q <= 1'b0;
            ot_fault_q <= 1'b0;
            rel_q <= 32'h0000_0000;
            pg_q <= 1'b0;
        end
        else
        begin
            if (!out_win)
                glitch_q <= 16'h0000;
            else if (glitch_q != 16'(`DEGLITCH_CYC))
                glitch_q <= glitch_q + 16'h0001;
            if (glitch_q == 16'(`DEGLITCH_CYC))
                win_fault_q <= 1'b1;
            else if (in_reg)
                win_fault_q <= 1'b0;
            if (s_ot)
                ot_fault_q <= 1'b1;
            else if (s_ot_clr && in_reg)
                ot_fault_q <= 1'b0;
            // a short trip out of band leaves the flag up; only the
            // deglitched window fault pulls it down
            if (any_fault || !s_vcc_ok)
            begin
                rel_q <= 32'h0000_0000;
                pg_q <= 1'b0;
            end
            else if (!in_reg && !pg_q)
                rel_q <= 32'h0000_0000;
            else if (rel_q >= RELEASE_CYC)
                pg_q <= 1'b1;
            else
                rel_q <= rel_q + 32'h0000_0001;
        end
    end

    // apb slave: one wait state, answered on second access cycle
    wire [31:0] stat_val = {24'h000000, pg_q, phase_q != 6'h00, locked_q,
        state_q == pwr_seq_pkg::ST_RUN, state_q != pwr_seq_pkg::ST_OFF,
        win_fault_q, ot_fault_q, en_q};
    wire [31:0] rd_val = hit_ctrl ? ctrl_q : hit_stat ? stat_val
        : hit_sync ? {16'h0000, sync_per_q} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `CTRL_RESET;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= acc;
            pslverr_q <= acc & ~hit_any;
            prdata_q <= (acc && !pwrite) ? rd_val : 32'h0000_0000;
            if (wr_ctrl)
                ctrl_q <= {31'h0, pwdata[`CTRL_SSC_BIT]};
        end
    end

    // registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            internal_supply_en <= 1'b0;
            phase_node_en <= 1'b0;
            // start from the main input until aux is seen good
            use_main_input <= 1'b1;
            ssc_en <= 1'b0;
            sync_locked <= 1'b0;
            phase_adjusting <= 1'b0;
            power_ok_flag_o <= 1'b0;
            power_ok_flag_oe <= 1'b1;
        end
        else
        begin
            internal_supply_en <= state_q != pwr_seq_pkg::ST_OFF;
            phase_node_en <= (state_q == pwr_seq_pkg::ST_SOFT
                || state_q == pwr_seq_pkg::ST_RUN) && !s_uvlo;
            use_main_input <= ~s_aux;
            // dither stops while an external clock is followed
            ssc_en <= ctrl_q[`CTRL_SSC_BIT] & ~locked_q;
            sync_locked <= locked_q;
            phase_adjusting <= phase_q != 6'h00;
            // open drain: the pad only ever pulls the line low
            power_ok_flag_o <= 1'b0;
            power_ok_flag_oe <= ~pg_q;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule

// *** src/pwr_seq_regs.svh ***
// register map, field positions, reset values and timing counts
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH
`define CTRL_OFS 12'h000
`define STAT_OFS 12'h004
`define SYNC_OFS 12'h008
`define CTRL_RESET 32'h0000_0001
`define CTRL_SSC_BIT 0
`define CLK_MHZ 25
`define BLANK_MIN_US 4
`define BLANK_MAX_US 28
`define BLANK_CYC (`BLANK_MAX_US * `CLK_MHZ)
`define SYNC_LOCK_CNT 2048
`define SYNC_MIN_PER_CYC (`CLK_MHZ * 1000 / 2200)
`define SYNC_MAX_PER_CYC (`CLK_MHZ * 1000 / 200)
`define DEGLITCH_US 20
`define DEGLITCH_CYC (`DEGLITCH_US * `CLK_MHZ)
`define RELEASE_US 2000
`define RELEASE_CYC (`RELEASE_US * `CLK_MHZ)
`define RAMP_US 5000
`define RAMP_CYC (`RAMP_US * `CLK_MHZ)
`define PHASE_STEPS 32
`endif

// *** src/pwr_seq_pkg.sv ***
// types for the enable, sync and power-good controller
package pwr_seq_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAKE,
        ST_SOFT,
        ST_RUN
    } seq_state_t;
endpackage

// *** test/enable_sync_power_good_ctrl_checker.sv ***
// port assertions for the enable, sync and power-good controller
`timescale 1ns/1ns
module enable_sync_power_good_ctrl_checker #(
    parameter int unsigned RELEASE_CYC = 50000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic turn_on_cmp,
    input wire logic vin_ok_cmp,
    input wire logic rt_ok_cmp,
    input wire logic fb_in_band_cmp,
    input wire logic vcc_uvlo_cmp,
    input wire logic aux_supply_ok_cmp,
    input wire logic internal_supply_en,
    input wire logic phase_node_en,
    input wire logic use_main_input,
    input wire logic ssc_en,
    input wire logic sync_locked,
    input wire logic phase_adjusting,
    input wire logic power_ok_flag_oe
);
    logic [9:0] lo_q;
    logic [31:0] band_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // enable-low run length and in-band run length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lo_q <= 10'h000;
            band_q <= 32'h0;
        end
        else
        begin
            lo_q <= turn_on_cmp ? 10'h000 : lo_q + {9'h000, lo_q != 10'h3FF};
            band_q <= fb_in_band_cmp ? band_q + 32'h1 : 32'h0;
        end
    end
    off_flag_low_a: assert property (lo_q > 10'h2D0 |->
        !phase_node_en && power_ok_flag_oe) else $error("enable low ignored");
    asleep_no_switch_a: assert property (!internal_supply_en |->
        !phase_node_en) else $error("switching without supply");
    vin_gate_a: assert property (!vin_ok_cmp [*6] |-> !phase_node_en)
        else $error("switching with low input");
    rt_shut_a: assert property (!rt_ok_cmp [*6] |-> !phase_node_en)
        else $error("switching with bad resistor");
    uvlo_inhibit_a: assert property (vcc_uvlo_cmp [*6] |->
        !phase_node_en) else $error("switching under lockout");
    aux_select_a: assert property ($stable(aux_supply_ok_cmp) [*6] |->
        use_main_input == !aux_supply_ok_cmp) else $error("supply select");
    lock_ssc_a: assert property ($rose(sync_locked) |-> ##[0:1] !ssc_en)
        else $error("dither kept while locked");
    lock_phase_a: assert property ($rose(sync_locked) |->
        ##[0:2] phase_adjusting) else $error("no phase slide");
    release_wait_a: assert property ($fell(power_ok_flag_oe) |->
        band_q >= RELEASE_CYC) else $error("flag released early");
    cover property ($rose(sync_locked));
    cover property ($fell(power_ok_flag_oe));
    cover property (lo_q > 10'h2D0);
endmodule

bind enable_sync_power_good_ctrl enable_sync_power_good_ctrl_checker
    #(.RELEASE_CYC(RELEASE_CYC)) chk (.pclk, .presetn, .turn_on_cmp,
    .vin_ok_cmp, .rt_ok_cmp, .fb_in_band_cmp, .vcc_uvlo_cmp,
    .aux_supply_ok_cmp, .internal_supply_en, .phase_node_en,
    .use_main_input, .ssc_en, .sync_locked, .phase_adjusting,
    .power_ok_flag_oe);

// *** test/sync_source_model.sv ***
// system logic driving the enable/sync input and reading the flag
`timescale 1ns/1ns
module sync_source_model (
    input wire logic clk,
    input wire logic en_req,
    input wire logic en_full,
    input wire logic sync_on,
    input wire logic [6:0] half_per,
    input wire logic flag_oe,
    output logic wake_cmp,
    output logic turn_on_cmp,
    output logic sync_edge_in,
    output logic pg_seen
);
    logic [6:0] cnt_q;
    logic tog_q;
    // pull-up resistor on the flag line
    assign pg_seen = !flag_oe;
    assign wake_cmp = en_req;
    // coupled pulses dip below turn-on but not below wake level
    assign sync_edge_in = en_full ^ tog_q;
    assign turn_on_cmp = sync_edge_in;
    always_ff @(posedge clk)
    begin
        if (!sync_on)
        begin
            cnt_q <= 7'h01;
            tog_q <= 1'b0;
        end
        else if (cnt_q >= half_per)
        begin
            cnt_q <= 7'h01;
            tog_q <= !tog_q;
        end
        else
            cnt_q <= cnt_q + 7'h01;
    end
endmodule

// *** test/enable_sync_power_good_ctrl_tb_top.sv ***
// self-checking bench for the enable, sync and power-good controller
`timescale 1ns/1ns
`define CHK(n, a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
 $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module enable_sync_power_good_ctrl_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic wake_cmp, turn_on_cmp, sync_edge_in, vin_ok_cmp, rt_ok_cmp;
    logic fb_under_cmp, fb_over_cmp, fb_in_band_cmp, overtemp_trip;
    logic overtemp_clear, vcc_uvlo_cmp, vcc_ok_cmp, aux_supply_ok_cmp;
    logic out_full_cmp, internal_supply_en, phase_node_en, use_main_input;
    logic ssc_en, sync_locked, phase_adjusting, power_ok_flag_o;
    logic power_ok_flag_oe, en_req, en_full, sync_on, pg;
    logic [6:0] hp;
    logic [33:0] ex;
    logic [33:0] exp_q[$];
    int bad_count, n_tests, n, k;
    enable_sync_power_good_ctrl #(.RELEASE_CYC(20), .RAMP_CYC(50),
        .LOCK_CNT(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .wake_cmp,
        .turn_on_cmp, .sync_edge_in, .vin_ok_cmp, .rt_ok_cmp, .fb_under_cmp,
        .fb_over_cmp, .fb_in_band_cmp, .overtemp_trip, .overtemp_clear,
        .vcc_uvlo_cmp, .vcc_ok_cmp, .aux_supply_ok_cmp, .out_full_cmp,
        .internal_supply_en, .phase_node_en, .use_main_input, .ssc_en,
        .sync_locked, .phase_adjusting, .power_ok_flag_o, .power_ok_flag_oe);
    sync_source_model src (.clk(pclk), .en_req, .en_full, .sync_on,
        .half_per(hp), .flag_oe(power_ok_flag_oe), .wake_cmp, .turn_on_cmp,
        .sync_edge_in, .pg_seen(pg));
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic wt(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++)
            @(posedge pclk);
    endtask
    // e holds read flag, expected error and expected data
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [33:0] e);
        int i;
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++i < 50);
        if (pready !== 1'b1)
            bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    always @(posedge pclk)
        if (pready === 1'b1)
        begin
            ex = exp_q.pop_front();
            `CHK("pslverr", pslverr, ex[32])
            if (ex[33])
                `CHK("prdata", prdata, ex[31:0])
        end
    initial
    begin
        repeat (60000) @(posedge pclk);
        bad_count++;
        results();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {en_req, en_full, sync_on, fb_under_cmp, fb_over_cmp} = '0;
        {fb_in_band_cmp, overtemp_trip, vcc_uvlo_cmp, out_full_cmp} = '0;
        {vin_ok_cmp, rt_ok_cmp, overtemp_clear, vcc_ok_cmp} = 4'hF;
        aux_supply_ok_cmp = 1'b0;
        hp = 7'h0A;
        n = $urandom(32'hF760);
        cyc(20);
        presetn <= 1'b1;
        cyc(2);
        apb(1'b0, 12'h000, 32'h0, 34'h2_0000_0001);
        apb(1'b1, 12'h000, 32'h0, 34'h0_0000_0000);
        apb(1'b0, 12'h000, 32'h0, 34'h2_0000_0000);
        `CHK("ssc_en", ssc_en, 1'b0)
        apb(1'b1, 12'h000, 32'h1, 34'h0_0000_0000);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF, 34'h1_0000_0000);
        apb(1'b0, 12'h00C, 32'h0, 34'h3_0000_0000);
        $display("registers done");
        `CHK("flag drive", power_ok_flag_o, 1'b0)
        `CHK("supply", internal_supply_en, 1'b0)
        `CHK("flag", pg, 1'b0)
        en_req <= 1'b1;
        vin_ok_cmp <= 1'b0;
        cyc(10);
        `CHK("supply", internal_supply_en, 1'b1)
        `CHK("switch", phase_node_en, 1'b0)
        en_full <= 1'b1;
        cyc(10);
        `CHK("switch", phase_node_en, 1'b0)
        vin_ok_cmp <= 1'b1;
        cyc(10);
        `CHK("switch", phase_node_en, 1'b1)
        fb_in_band_cmp <= 1'b1;
        cyc(30);
        `CHK("flag", pg, 1'b0)
        wt(power_ok_flag_oe, 1'b0, 300);
        `CHK("flag", pg, 1'b1)
        apb(1'b0, 12'h004, 32'h0, 34'h2_0000_0099);
        $display("start-up done");
        for (k = 0; k < 2; k++)
        begin
            fb_in_band_cmp <= 1'b0;
            {fb_over_cmp, fb_under_cmp} <= k ? 2'h2 : 2'h1;
            cyc(20 + $urandom % 400);
            `CHK("flag", pg, 1'b1)
            cyc(600);
            `CHK("flag", pg, 1'b0)
            {fb_over_cmp, fb_under_cmp} <= 2'h0;
            cyc(5);
            `CHK("flag", pg, 1'b0)
            fb_in_band_cmp <= 1'b1;
            wt(power_ok_flag_oe, 1'b0, 300);
            `CHK("flag", pg, 1'b1)
        end
        for (k = 0; k < 2; k++)
        begin
            {overtemp_trip, overtemp_clear} <= k ? 2'h1 : 2'h2;
            {vcc_uvlo_cmp, vcc_ok_cmp} <= k ? 2'h2 : 2'h1;
            cyc(10);
            `CHK("flag", pg, 1'b0)
            {overtemp_trip, overtemp_clear, vcc_uvlo_cmp, vcc_ok_cmp} <= 4'h5;
            wt(power_ok_flag_oe, 1'b0, 500);
            `CHK("flag", pg, 1'b1)
        end
        repeat (4)
        begin
            aux_supply_ok_cmp <= 1'($urandom);
            cyc(8);
            `CHK("main", use_main_input, !aux_supply_ok_cmp)
        end
        $display("faults done");
        hp <= 7'(6 + $urandom % 35);
        sync_on <= 1'b1;
        wt(sync_locked, 1'b1, 3000);
        `CHK("lock", sync_locked, 1'b1)
        `CHK("ssc", ssc_en, 1'b0)
        `CHK("phase", phase_adjusting, 1'b1)
        `CHK("switch", phase_node_en, 1'b1)
        `CHK("flag", pg, 1'b1)
        apb(1'b0, 12'h008, 32'h0, {2'h2, 24'h000000, hp, 1'b0});
        sync_on <= 1'b0;
        cyc(300);
        `CHK("lock", sync_locked, 1'b0)
        rt_ok_cmp <= 1'b0;
        cyc(10);
        `CHK("switch", phase_node_en, 1'b0)
        rt_ok_cmp <= 1'b1;
        {en_req, en_full} <= 2'h0;
        cyc(800);
        `CHK("supply", internal_supply_en, 1'b0)
        `CHK("flag", pg, 1'b0)
        $display("sync and shutdown done");
        results();
    end
endmodule
